// file: rtl/rfet_pkg.sv
// package: register map, field layout and timing constants of the rf timer
package rfet_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W         = 12;
   localparam logic [11:0] CFG_INDEX      = 12'h010;
   localparam logic [11:0] CFG_ADDR       = CFG_INDEX << 2;
   localparam logic [11:0] PRESET_ADDR    = 12'h044;
   localparam logic [11:0] VALUE_ADDR     = 12'h048;
   localparam logic [11:0] STATUS_ADDR    = 12'h04C;
   localparam logic [11:0] MASK_ADDR      = 12'h050;

   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   localparam int          CFG_ENABLE     = 0;
   localparam int          CFG_RELOAD     = 1;
   localparam int          CFG_CLK_SRC    = 2;
   localparam int          CFG_RATE_LO    = 3;
   localparam int          CFG_RATE_HI    = 5;
   localparam int          CFG_START_NOW  = 6;
   localparam int          CFG_START_LO   = 7;
   localparam int          CFG_START_HI   = 14;
   localparam int          CFG_STOP_LO    = 15;
   localparam int          CFG_STOP_HI    = 20;
   localparam logic [31:0] CFG_WMASK      = 32'h001F_FFFF;
   localparam logic [31:0] CFG_RESET      = 32'h0000_0000;

   // ---------------------------------------------------------------
   // status and interrupt fields
   // ---------------------------------------------------------------
   localparam int          ST_W           = 3;
   localparam int          ST_EXPIRED     = 0;
   localparam int          ST_STARTED     = 1;
   localparam int          ST_STOPPED     = 2;
   localparam logic [2:0]  ST_RESET       = 3'h0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam longint      CORE_CLK_HZ    = 125_000_000;
   localparam longint      RF_CLK_HZ      = 13_560_000;
   localparam int          PHASE_W        = 24;
   localparam logic [23:0] PHASE_INC      =
      24'((RF_CLK_HZ << PHASE_W) / CORE_CLK_HZ);
   localparam int          PRE_W          = 8;
   localparam int          SYNC_W         = 5;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   // order of start and stop fields matches the register bit order
   typedef struct packed {
      logic rx_nibble;
      logic rx_begin;
      logic rx_end;
      logic tx_begin;
      logic tx_end;
      logic ext_on;
      logic ext_off;
      logic own_on;
      logic own_off;
   } rfet_evt_s;

   typedef struct packed {
      logic       rx_bits_four;
      logic       rx_active;
      logic       tx_active;
      logic       ext_field;
      logic       own_field;
   } rfet_lvl_s;

endpackage

// file: rtl/rfet_tick_gen.sv
// tick source: 13.56 mhz rf-domain rate and its binary prescaled rates
`timescale 1ns/1ns
module rfet_tick_gen
   import rfet_pkg::*;
(
   input  wire logic       core_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic [2:0] rate_sel_in,
   output logic            rf_tick_out,
   output logic            pre_tick_out
);

   logic [PHASE_W-1:0] phase_r;
   logic [PRE_W-1:0]   div_r;
   logic [PHASE_W:0]   phase_sum;
   logic [PRE_W-1:0]   div_mask;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [PRE_W-1:0] low_ones(input logic [2:0] sel);
      low_ones = PRE_W'((9'h002 << sel) - 9'h001);
   endfunction

   assign phase_sum = {1'b0, phase_r} + {1'b0, PHASE_INC};
   assign div_mask  = low_ones(rate_sel_in);

   // ---------------------------------------------------------------
   // fractional accumulator, carry gives the rf-domain rate
   // ---------------------------------------------------------------
   // jitter of one core cycle per tick; average rate is exact to 24 bits
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phase_r     <= '0;
         rf_tick_out <= 1'b0;
      end else begin
         phase_r     <= phase_sum[PHASE_W-1:0];
         rf_tick_out <= phase_sum[PHASE_W];
      end
   end

   // ---------------------------------------------------------------
   // prescaler: code n divides the rf rate by two to the n+1
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         div_r        <= '0;
         pre_tick_out <= 1'b0;
      end else begin
         if (rf_tick_out) begin
            div_r <= div_r + PRE_W'(1);
         end
         pre_tick_out <= rf_tick_out && ((div_r & div_mask) == div_mask);
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_pre_rate;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      pre_tick_out |-> !rf_tick_out ##1 !pre_tick_out;
   endproperty
   a_pre_rate: assert property (p_pre_rate)
      else $error("prescaled tick faster than half rf rate");

endmodule

// file: rtl/rfet_timer.sv
// rf event timer: apb registers, event start/stop, down counter, interrupt
//
// Contract
// - start the timer when frame reception ends, if that selector is set
// - start the timer when transmission begins, if that selector is set
// - start the timer when transmission ends, if that selector is set
// - start the timer when an external field appears, if selected
// - start the timer when the external field vanishes, if selected
// - start the timer when the own field switches on, if selected
// - start the timer when the own field switches off, if selected
// - immediate start selector starts the timer without waiting for events, only if enable was already set before that write
// - tick-rate field bits 3..5: 6.78 mhz at 000, halving to 53 khz
// - clock-source bit 0 counts at 13.56 mhz, 1 at the prescaled tick
// - auto-reload clear: timer stops at expiry and holds zero
// - auto-reload set: timer reloads preset at expiry and keeps counting
// - timer operates only while enable bit 0 is set (reset value 0); clearing it holds the count
// - stop selectors in bits 15..20 halt the running timer on their events
// - reception-begin selector in bit 14 starts the timer on the first bit
`timescale 1ns/1ns
module rfet_timer
   import rfet_pkg::*;
#(
   parameter int CNT_W = 20
)(
   input  wire logic              core_clk_in,
   input  wire logic              reset_n_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   input  wire logic              rx_active_in,
   input  wire logic              rx_bits_four_in,
   input  wire logic              tx_active_in,
   input  wire logic              ext_field_in,
   input  wire logic              own_field_in,
   output logic                   timer_running_out,
   output logic                   timer_expired_out,
   output logic                   irq_out
);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_RUN   = 3'b100
   } rfet_state_e;

   rfet_state_e      state_r;
   rfet_state_e      state_nxt;
   logic [31:0]      cfg_r;
   logic [CNT_W-1:0] preset_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [ST_W-1:0]  status_r;
   logic [ST_W-1:0]  mask_r;
   logic [ST_W-1:0]  st_set;
   logic [ST_W-1:0]  st_clr;
   logic [ST_W-1:0]  status_nxt;
   rfet_lvl_s        sync1_r;
   rfet_lvl_s        sync2_r;
   rfet_lvl_s        prev_r;
   rfet_evt_s        evt;
   logic             now_pulse_r;
   logic             rf_tick;
   logic             pre_tick;
   logic             tick;
   logic             start_hit;
   logic             stop_hit;
   logic             expire;
   logic             bus_req;
   logic             bus_done;
   logic             wr_done;
   logic [7:0]       start_vec;
   logic [5:0]       stop_vec;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == CFG_ADDR) || (a == PRESET_ADDR) ||
                 (a == VALUE_ADDR) || (a == STATUS_ADDR) ||
                 (a == MASK_ADDR);
   endfunction

   // ---------------------------------------------------------------
   // apb slave: one wait cycle, effects at the pready edge
   // ---------------------------------------------------------------
   assign bus_req  = psel_in && penable_in && !pready_out;
   assign bus_done = psel_in && penable_in && pready_out;
   assign wr_done  = bus_done && pwrite_in && !pslverr_out;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= bus_req;
         pslverr_out <= bus_req && !addr_hit(paddr_in);
         if (bus_req && !pwrite_in) begin
            unique case (paddr_in)
               CFG_ADDR:    prdata_out <= cfg_r;
               PRESET_ADDR: prdata_out <= 32'(preset_r);
               VALUE_ADDR:  prdata_out <= 32'(count_r);
               STATUS_ADDR: prdata_out <= 32'(status_r);
               MASK_ADDR:   prdata_out <= 32'(mask_r);
               default:     prdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration, preset and mask registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_r       <= CFG_RESET;
         preset_r    <= '0;
         mask_r      <= ST_RESET;
         now_pulse_r <= 1'b0;
      end else begin
         now_pulse_r <= 1'b0;
         if (wr_done && paddr_in == CFG_ADDR) begin
            cfg_r       <= pwdata_in & CFG_WMASK;
            // immediate start fires once per write, not as a level
            now_pulse_r <= pwdata_in[CFG_START_NOW] && pwdata_in[CFG_ENABLE];
         end
         if (wr_done && paddr_in == PRESET_ADDR) begin
            preset_r <= pwdata_in[CNT_W-1:0];
         end
         if (wr_done && paddr_in == MASK_ADDR) begin
            mask_r <= pwdata_in[ST_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // rf status inputs: two-stage synchroniser, then edge detect
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end else begin
         sync1_r <= {rx_bits_four_in, rx_active_in, tx_active_in,
                     ext_field_in, own_field_in};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   always_comb begin
      evt.rx_nibble = sync2_r.rx_bits_four && !prev_r.rx_bits_four;
      evt.rx_begin  = sync2_r.rx_active && !prev_r.rx_active;
      evt.rx_end    = !sync2_r.rx_active && prev_r.rx_active;
      evt.tx_begin  = sync2_r.tx_active && !prev_r.tx_active;
      evt.tx_end    = !sync2_r.tx_active && prev_r.tx_active;
      evt.ext_on    = sync2_r.ext_field && !prev_r.ext_field;
      evt.ext_off   = !sync2_r.ext_field && prev_r.ext_field;
      evt.own_on    = sync2_r.own_field && !prev_r.own_field;
      evt.own_off   = !sync2_r.own_field && prev_r.own_field;
   end
   assign start_vec = {evt.rx_begin, evt.rx_end, evt.tx_begin, evt.tx_end,
                       evt.ext_on, evt.ext_off, evt.own_on, evt.own_off};
   assign stop_vec  = {evt.rx_nibble, evt.tx_begin, evt.ext_on,
                       evt.ext_off, evt.own_on, evt.own_off};

   // ---------------------------------------------------------------
   // tick selection
   // ---------------------------------------------------------------
   rfet_tick_gen u_tick (
      .core_clk_in  (core_clk_in),
      .reset_n_in   (reset_n_in),
      .rate_sel_in  (cfg_r[CFG_RATE_HI:CFG_RATE_LO]),
      .rf_tick_out  (rf_tick),
      .pre_tick_out (pre_tick)
   );
   assign tick = cfg_r[CFG_CLK_SRC] ? pre_tick : rf_tick;

   // ---------------------------------------------------------------
   // start, stop and expiry
   // ---------------------------------------------------------------
   // any selected event starts; only the armed state listens
   assign start_hit = (state_r == ST_ARMED) &&
                      ((|(start_vec & cfg_r[CFG_START_HI:CFG_START_LO])) ||
                       now_pulse_r);
   assign stop_hit  = (state_r == ST_RUN) &&
                      (|(stop_vec & cfg_r[CFG_STOP_HI:CFG_STOP_LO]));
   // a preset of zero expires on the first tick
   assign expire    = (state_r == ST_RUN) && tick && !stop_hit &&
                      (count_r <= CNT_W'(1));

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  state_nxt = ST_ARMED;
         ST_ARMED: if (start_hit) begin
            state_nxt = ST_RUN;
         end
         ST_RUN:   if (stop_hit || (expire && !cfg_r[CFG_RELOAD])) begin
            state_nxt = ST_ARMED;
         end
      endcase
      if (!cfg_r[CFG_ENABLE]) begin
         state_nxt = ST_IDLE;
      end
   end

   always_comb begin
      count_nxt = count_r;
      if (start_hit) begin
         count_nxt = preset_r;
      end else if (expire) begin
         count_nxt = cfg_r[CFG_RELOAD] ? preset_r : '0;
      end else if (state_r == ST_RUN && tick && !stop_hit) begin
         count_nxt = count_r - CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= ST_IDLE;
         count_r <= '0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
      end
   end

   // ---------------------------------------------------------------
   // status, interrupt and event outputs
   // ---------------------------------------------------------------
   assign st_set     = {stop_hit, start_hit && cfg_r[CFG_ENABLE], expire};
   assign st_clr     = (wr_done && paddr_in == STATUS_ADDR) ?
                       pwdata_in[ST_W-1:0] : '0;
   // set wins over a write-one clear in the same cycle
   assign status_nxt = (status_r & ~st_clr) | st_set;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         status_r <= ST_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_out           <= 1'b0;
         timer_expired_out <= 1'b0;
         timer_running_out <= 1'b0;
      end else begin
         irq_out           <= |(status_nxt & mask_r);
         timer_expired_out <= expire;
         timer_running_out <= (state_nxt == ST_RUN);
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_enable_gate;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !cfg_r[CFG_ENABLE] |=> (state_r == ST_IDLE) && !timer_running_out;
   endproperty
   a_enable_gate: assert property (p_enable_gate)
      else $error("timer active while disabled");
   property p_start_now;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == ST_ARMED) && cfg_r[CFG_ENABLE] && now_pulse_r
      |=> (state_r == ST_RUN) && (count_r == $past(preset_r));
   endproperty
   a_start_now: assert property (p_start_now)
      else $error("immediate start did not load preset");
   property p_rx_end_start;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == ST_ARMED) && cfg_r[CFG_ENABLE] && cfg_r[CFG_START_HI-1] &&
      evt.rx_end |=> (state_r == ST_RUN) && timer_running_out;
   endproperty
   a_rx_end_start: assert property (p_rx_end_start)
      else $error("reception end did not start timer");
   property p_own_on_start;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      $rose(sync2_r.own_field) && (state_r == ST_ARMED) &&
      cfg_r[CFG_ENABLE] && cfg_r[CFG_START_LO+1] |=> state_r == ST_RUN;
   endproperty
   a_own_on_start: assert property (p_own_on_start)
      else $error("own field on did not start timer");
   property p_no_reload;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      expire && cfg_r[CFG_ENABLE] && !cfg_r[CFG_RELOAD]
      |=> (count_r == '0) && (state_r == ST_ARMED) && timer_expired_out;
   endproperty
   a_no_reload: assert property (p_no_reload)
      else $error("timer did not halt at zero");
   property p_reload;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      expire && cfg_r[CFG_ENABLE] && cfg_r[CFG_RELOAD]
      |=> (count_r == $past(preset_r)) && (state_r == ST_RUN);
   endproperty
   a_reload: assert property (p_reload)
      else $error("timer did not reload preset");
   property p_expire_flag;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      expire |=> timer_expired_out && status_r[ST_EXPIRED]
      ##1 !timer_expired_out;
   endproperty
   a_expire_flag: assert property (p_expire_flag)
      else $error("expiry not reported");
   property p_ignore_start;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == ST_RUN) && cfg_r[CFG_ENABLE] && !tick &&
      !stop_hit && (|start_vec) |=> count_r == $past(count_r);
   endproperty
   a_ignore_start: assert property (p_ignore_start)
      else $error("start event disturbed running timer");
   property p_stop;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      stop_hit && cfg_r[CFG_ENABLE] |=> (state_r == ST_ARMED) &&
      (count_r == $past(count_r)) && !timer_running_out;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop event did not halt timer");
   property p_rf_rate;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == ST_RUN) && cfg_r[CFG_ENABLE] && !cfg_r[CFG_CLK_SRC] &&
      rf_tick && !stop_hit && (count_r > CNT_W'(1))
      |=> count_r == $past(count_r) - CNT_W'(1);
   endproperty
   a_rf_rate: assert property (p_rf_rate)
      else $error("timer missed an rf-domain tick");
endmodule

// file: test/rfet_timer_bench.sv
// testbench: apb register access and event-driven timer behaviour
`timescale 1ns/1ns
module rfet_timer_bench;
   import rfet_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic              core_clk_in;
   logic              reset_n_in;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [4:0]        lv;
   logic              running;
   logic              expired;
   logic              irq;
   logic              last_err;
   logic [31:0]       q;
   logic [31:0]       cfg;
   int                n_errors;
   int                total_checks;
   int                c;
   int                s;
   int                ssig[6] = '{4, 1, 2, 2, 3, 3};
   logic [5:0]        srise = 6'h17;
   logic              rise;
   real               e;

   rfet_timer uut (
      .core_clk_in       (core_clk_in),
      .reset_n_in        (reset_n_in),
      .psel_in           (psel),
      .penable_in        (penable),
      .pwrite_in         (pwrite),
      .paddr_in          (paddr),
      .pwdata_in         (pwdata),
      .prdata_out        (prdata),
      .pready_out        (pready),
      .pslverr_out       (pslverr),
      .rx_active_in      (lv[0]),
      .rx_bits_four_in   (lv[4]),
      .tx_active_in      (lv[1]),
      .ext_field_in      (lv[2]),
      .own_field_in      (lv[3]),
      .timer_running_out (running),
      .timer_expired_out (expired),
      .irq_out           (irq)
   );

   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic fail_wait();
      n_errors++;
      $display("Error at %0t: wait ran out", $time);
      close_out();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // hold the request until pready is sampled high, then release
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      int n;
      @(posedge core_clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk_in);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk_in);
         if (pready === 1'b1) break;
      end
      if (n == 20) fail_wait();
      rd = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, a, d, rd);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      apb(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask

   // level waits are bounded; event sync adds a few cycles of delay
   task automatic wait_run(input logic lvl);
      int n;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk_in);
         if (running === lvl) break;
      end
      if (n == 40) fail_wait();
      total_checks++;
   endtask

   task automatic wait_exp(output int cyc);
      for (cyc = 1; cyc < 3000; cyc++) begin
         @(posedge core_clk_in);
         if (expired === 1'b1) break;
      end
      if (cyc == 3000) fail_wait();
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      lv = 5'h0;
      n_errors = 0;
      total_checks = 0;
      repeat (16) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      rdc(CFG_ADDR, CFG_RESET);
      wr(CFG_ADDR, 32'hFFFF_FFFF);
      rdc(CFG_ADDR, CFG_WMASK);
      wr(CFG_ADDR, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0, q);
      chk({31'h0, last_err}, 32'h1);
      // one-shot run: stops at zero, interrupt through mask
      wr(PRESET_ADDR, 32'h5);
      wr(MASK_ADDR, 32'h1);
      wr(CFG_ADDR, 32'h1);
      wr(CFG_ADDR, 32'h41);
      wait_run(1'b1);
      wait_exp(c);
      repeat (3) @(posedge core_clk_in);
      chk({31'h0, running}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rdc(VALUE_ADDR, 32'h0);
      rdc(STATUS_ADDR, 32'h3);
      wr(STATUS_ADDR, 32'h1);
      repeat (2) @(posedge core_clk_in);
      chk({31'h0, irq}, 32'h0);
      rdc(STATUS_ADDR, 32'h2);
      wr(CFG_ADDR, 32'h0);
      // tick period: rf clock, then every prescaled rate, auto reload
      wr(PRESET_ADDR, 32'h0);
      for (int k = -1; k < 8; k++) begin
         cfg = (k < 0) ? 32'h3 : (32'h7 | (32'(k) << 3));
         wr(CFG_ADDR, cfg);
         wr(CFG_ADDR, cfg | 32'h40);
         wait_exp(c);
         wait_exp(c);
         e = 125.0 / 13.56 * (2.0 ** (k + 1));
         chk({31'h0, (c > e - 2.0) && (c < e + 2.0)}, 32'h1);
         chk({31'h0, running}, 32'h1);
         wr(CFG_ADDR, 32'h0);
      end
      // start selectors: each edge of each field or link level
      wr(PRESET_ADDR, 32'h000F_FFFF);
      for (int b = 7; b <= 14; b++) begin
         s = (14 - b) / 2;
         rise = ((14 - b) % 2 == 0);
         lv[s] <= !rise;
         wr(CFG_ADDR, 32'h1);
         wr(CFG_ADDR, 32'h1 | (32'h1 << b));
         repeat (8) @(posedge core_clk_in);
         chk({31'h0, running}, 32'h0);
         lv[s] <= rise;
         wait_run(1'b1);
         // opposite edge while running must not stop the timer
         lv[s] <= !rise;
         repeat (8) @(posedge core_clk_in);
         chk({31'h0, running}, 32'h1);
         wr(CFG_ADDR, 32'h0);
         wait_run(1'b0);
         lv <= 5'h0;
         repeat (8) @(posedge core_clk_in);
      end
      // stop selectors halt a running timer
      for (int j = 0; j < 6; j++) begin
         s = ssig[j];
         lv[s] <= !srise[j];
         wr(CFG_ADDR, 32'h1);
         wr(STATUS_ADDR, 32'h7);
         wr(CFG_ADDR, 32'h41 | (32'h1 << (20 - j)));
         wait_run(1'b1);
         lv[s] <= srise[j];
         wait_run(1'b0);
         rdc(STATUS_ADDR, 32'h6);
         wr(CFG_ADDR, 32'h0);
         lv <= 5'h0;
         repeat (8) @(posedge core_clk_in);
      end
      close_out();
   end
endmodule
